// ### design/pcstk_unit.v
// program counter, return stack and status flag unit
//
// Strobed register access and the register addresses were left to the implementer.
`include "pcstk_consts.vh"
module pcstk_unit #(
   parameter DEPTH_LOG2 = 4
) (
   // clock, reset, enable
   input wire i_core_clk,
   input wire i_nrst,
   input wire i_ce,
   // fault reset configuration
   input wire i_stack_fault_reset_enable,
   // instruction control
   input wire i_fetch,
   input wire i_call,
   input wire i_call_via_w,
   input wire i_branch_by_w,
   input wire i_branch_relative,
   input wire i_int_vector,
   input wire i_return,
   input wire [10:0] i_operand,
   input wire [8:0] i_rel_offset,
   input wire [7:0] i_working_register,
   // alu flag update
   input wire i_alu_valid,
   input wire i_alu_sub,
   input wire [7:0] i_alu_a,
   input wire [7:0] i_alu_b,
   input wire i_alu_logic,
   input wire [7:0] i_alu_logic_result,
   input wire i_alu_upd_z,
   input wire i_alu_upd_cdc,
   // device events
   input wire i_por,
   input wire i_clrwdt,
   input wire i_sleep,
   input wire i_wdt_timeout,
   // register port
   input wire [11:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   // outputs
   output reg [14:0] o_pc,
   output reg [7:0] o_rdata,
   output reg [4:0] o_status,
   output reg o_stack_overflow_flag,
   output reg o_stack_underflow_flag,
   output reg o_fault_reset
);
   localparam DEPTH = 1 << DEPTH_LOG2;
   localparam [4:0] SP_TOP = DEPTH - 1;

   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   reg [14:0] stack_mem [0:DEPTH-1];
   reg [4:0] sp_ff;
   reg [6:0] pc_high_latch_ff;
   reg [14:0] nxt_pc;
   reg [4:0] nxt_sp;
   reg [4:0] nxt_status;
   reg push;
   reg pop;
   reg ovf;
   reg unf;
   reg [8:0] sum;
   reg [4:0] nib;
   reg [7:0] res;
   wire [14:0] pc_inc;
   wire [DEPTH_LOG2-1:0] sp_idx;
   wire [DEPTH_LOG2-1:0] push_idx;
   wire wr_pc_low;
   wire wr_status;

   assign pc_inc = o_pc + 15'h0001;
   assign sp_idx = sp_ff[DEPTH_LOG2-1:0];
   assign push_idx = nxt_sp[DEPTH_LOG2-1:0];
   assign wr_pc_low = i_wr && (i_addr == `PCSTK_ADDR_PC_LOW);
   assign wr_status = i_wr && (i_addr == `PCSTK_ADDR_STATUS);

   //------------------------------------------------------------
   // next program counter and stack pointer
   //------------------------------------------------------------
   always @* begin
      nxt_pc = o_pc;
      push = 1'b0;
      pop = 1'b0;
      if (i_call) begin
         nxt_pc = {pc_high_latch_ff[6:3], i_operand};
         push = 1'b1;
      end else if (i_call_via_w) begin
         nxt_pc = {pc_high_latch_ff, i_working_register};
         push = 1'b1;
      end else if (i_int_vector) begin
         nxt_pc = {11'h000, 4'h4};
         push = 1'b1;
      end else if (i_return) begin
         nxt_pc = stack_mem[sp_idx];
         pop = 1'b1;
      end else if (i_branch_by_w) begin
         nxt_pc = pc_inc + {7'h00, i_working_register};
      end else if (i_branch_relative) begin
         nxt_pc = pc_inc + {{6{i_rel_offset[8]}}, i_rel_offset};
      end else if (wr_pc_low) begin
         nxt_pc = {pc_high_latch_ff, i_wdata};
      end else if (i_fetch) begin
         nxt_pc = pc_inc;
      end
      nxt_sp = sp_ff;
      if (push) begin
         nxt_sp = sp_ff + 5'h01;
      end else if (pop) begin
         nxt_sp = sp_ff - 5'h01;
      end
      ovf = push && (sp_ff == SP_TOP);
      unf = pop && (sp_ff == `PCSTK_SP_RST);
   end

   //------------------------------------------------------------
   // status flags
   //------------------------------------------------------------
   always @* begin
      nxt_status = o_status;
      sum = 9'h000;
      nib = 5'h00;
      res = 8'h00;
      if (wr_status) begin
         nxt_status[2:0] = i_wdata[2:0];
      end
      if (i_alu_valid) begin
         if (i_alu_logic) begin
            res = i_alu_logic_result;
         end else if (i_alu_sub) begin
            sum = {1'b0, i_alu_a} + {1'b0, ~i_alu_b} + 9'h001;
            nib = {1'b0, i_alu_a[3:0]} + {1'b0, ~i_alu_b[3:0]} + 5'h01;
            res = sum[7:0];
         end else begin
            sum = {1'b0, i_alu_a} + {1'b0, i_alu_b};
            nib = {1'b0, i_alu_a[3:0]} + {1'b0, i_alu_b[3:0]};
            res = sum[7:0];
         end
         if (i_alu_upd_z) begin
            nxt_status[`PCSTK_ST_Z] = (res == 8'h00);
         end
         if (i_alu_upd_cdc) begin
            nxt_status[`PCSTK_ST_C] = sum[8];
            nxt_status[`PCSTK_ST_DIGIT_CARRY] = nib[4];
         end
      end
      if (i_sleep) begin
         nxt_status[`PCSTK_ST_POWER_DOWN] = 1'b0;
         nxt_status[`PCSTK_ST_TIMEOUT] = 1'b1;
      end
      if (i_clrwdt) begin
         nxt_status[`PCSTK_ST_POWER_DOWN] = 1'b1;
         nxt_status[`PCSTK_ST_TIMEOUT] = 1'b1;
      end
      if (i_wdt_timeout) begin
         nxt_status[`PCSTK_ST_TIMEOUT] = 1'b0;
      end
      if (i_por) begin
         nxt_status = `PCSTK_STATUS_RST;
      end
   end

   //------------------------------------------------------------
   // sequential state
   //------------------------------------------------------------
   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pc <= 15'h0000;
         sp_ff <= `PCSTK_SP_RST;
         pc_high_latch_ff <= 7'h00;
         o_status <= `PCSTK_STATUS_RST;
         o_stack_overflow_flag <= 1'b0;
         o_stack_underflow_flag <= 1'b0;
         o_fault_reset <= 1'b0;
         o_rdata <= 8'h00;
      end else if (i_ce) begin
         o_status <= nxt_status;
         o_fault_reset <= 1'b0;
         if ((ovf || unf) && i_stack_fault_reset_enable) begin
            o_pc <= 15'h0000;
            sp_ff <= `PCSTK_SP_RST;
            o_fault_reset <= 1'b1;
         end else begin
            o_pc <= nxt_pc;
            sp_ff <= nxt_sp;
         end
         if (ovf) begin
            o_stack_overflow_flag <= 1'b1;
         end
         if (unf) begin
            o_stack_underflow_flag <= 1'b1;
         end
         if (i_wr && i_addr == `PCSTK_ADDR_PC_LATCH) begin
            pc_high_latch_ff <= i_wdata[6:0];
         end
         if (i_wr && i_addr == `PCSTK_ADDR_STK_POINTER && !push && !pop) begin
            sp_ff <= i_wdata[4:0];
         end
         o_rdata <= 8'h00;
         if (i_rd) begin
            case (i_addr)
               `PCSTK_ADDR_PC_LOW: o_rdata <= o_pc[7:0];
               `PCSTK_ADDR_STATUS: o_rdata <= {3'h0, o_status};
               `PCSTK_ADDR_PC_LATCH: o_rdata <= {1'b0, pc_high_latch_ff};
               `PCSTK_ADDR_STK_POINTER: o_rdata <= {3'h0, sp_ff};
               `PCSTK_ADDR_TOS_LOW: o_rdata <= stack_mem[sp_idx][7:0];
               `PCSTK_ADDR_TOS_HIGH: o_rdata <= {1'b0, stack_mem[sp_idx][14:8]};
               default: o_rdata <= 8'h00;
            endcase
         end
      end
   end

   //------------------------------------------------------------
   // stack storage, no reset
   //------------------------------------------------------------
   always @(posedge i_core_clk) begin
      if (i_ce) begin
         if (push) begin
            stack_mem[push_idx] <= i_int_vector && !i_call && !i_call_via_w ? o_pc : pc_inc;
         end else if (i_wr && i_addr == `PCSTK_ADDR_TOS_LOW) begin
            stack_mem[sp_idx][7:0] <= i_wdata;
         end else if (i_wr && i_addr == `PCSTK_ADDR_TOS_HIGH) begin
            stack_mem[sp_idx][14:8] <= i_wdata[6:0];
         end
      end
   end
endmodule

// ### design/pcstk_consts.vh
// constants for the program counter, return stack and status flag unit
// How it works
// - program counter is 15 bits; low byte readable/writable, high bits from latch
// - i_nrst and fault reset clear the whole program counter; i_por does not
// - writing the low byte also loads PC[14:8] from the high latch
// - immediate call: operand gives PC[10:0], latch bits 6..3 give PC[14:11]
// - call via W: low byte from W, high bits from the latch
// - branch by W: PC becomes PC+1 plus unsigned W
// - relative branch: PC becomes PC+1 plus signed operand, any page
// - dedicated 16 by 15-bit return stack outside memory spaces
// - push on calls and interrupt vector; pop on returns
// - pushes and pops never change the high latch
// - with fault reset off the stack wraps circularly
// - overflow and underflow flags set whatever the fault reset setting
// - with fault reset on, overflow or underflow resets the device
// - software reads/writes pointer and top-of-stack pair at pointer slot
// - stack pointer is five bits wide to detect faults
// - push increments then writes; pop reads then decrements
// - status writes to zero, digit carry, carry lose to that instruction's computed flags
// - writes to timeout and power-down flags are ignored
// - in subtraction carry and digit carry are inverted borrows
// - unimplemented locations read as zero
// - digit carry is carry out of bit 3, carry is carry out of bit 7
// - Z set when a result is zero, cleared otherwise
// - power-down flag set at power-up and watchdog clear, cleared by sleep
`ifndef PCSTK_CONSTS_VH
`define PCSTK_CONSTS_VH
`define PCSTK_ADDR_PC_LOW 12'h002
`define PCSTK_ADDR_STATUS 12'h003
`define PCSTK_ADDR_PC_LATCH 12'h00A
`define PCSTK_ADDR_STK_POINTER 12'hFED
`define PCSTK_ADDR_TOS_LOW 12'hFEE
`define PCSTK_ADDR_TOS_HIGH 12'hFEF
`define PCSTK_ST_C 0
`define PCSTK_ST_DIGIT_CARRY 1
`define PCSTK_ST_Z 2
`define PCSTK_ST_POWER_DOWN 3
`define PCSTK_ST_TIMEOUT 4
`define PCSTK_SP_RST 5'h1F
`define PCSTK_STATUS_RST 5'h18
`endif

// ### test/pcstk_unit_props.sv
// checker for the program counter, stack and status unit
`include "pcstk_consts.vh"
module pcstk_unit_props #(parameter DEPTH_LOG2 = 4) (
   input wire i_core_clk, i_nrst, i_ce, i_stack_fault_reset_enable, i_fetch, i_call,
   input wire i_call_via_w, i_branch_by_w, i_branch_relative, i_int_vector, i_return,
   input wire [10:0] i_operand,
   input wire [8:0] i_rel_offset,
   input wire [7:0] i_working_register,
   input wire [11:0] i_addr,
   input wire i_wr, i_por, i_sleep, i_clrwdt, i_wdt_timeout,
   input wire [14:0] o_pc,
   input wire [4:0] o_status,
   input wire o_stack_overflow_flag, o_fault_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   wire stk_op = i_call | i_call_via_w | i_int_vector | i_return;
   wire no_fre = !i_stack_fault_reset_enable;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   chk_call_target: assert property (i_ce && i_call && no_fre
      |=> o_pc[10:0] == $past(i_operand)) else $error("call target wrong");
   chk_call_w_low: assert property (i_ce && i_call_via_w && !i_call && no_fre
      |=> o_pc[7:0] == $past(i_working_register)) else $error("call via w target wrong");
   chk_branch_w_target: assert property (i_ce && i_branch_by_w && !stk_op
      |=> o_pc == $past(o_pc) + 15'h1 + {7'h0, $past(i_working_register)})
      else $error("branch by w target wrong");
   chk_branch_rel_target: assert property (i_ce && i_branch_relative && !stk_op && !i_branch_by_w
      |=> o_pc == $past(o_pc) + 15'h1 + {{6{$past(i_rel_offset[8])}}, $past(i_rel_offset)})
      else $error("relative branch target wrong");
   chk_fetch_step: assert property (i_ce && i_fetch && !stk_op && !i_branch_by_w
      && !i_branch_relative && !(i_wr && i_addr == `PCSTK_ADDR_PC_LOW)
      |=> o_pc == $past(o_pc) + 15'h1) else $error("fetch step wrong");
   chk_status_ro: assert property (i_ce && i_wr && i_addr == `PCSTK_ADDR_STATUS
      && !(i_por | i_sleep | i_clrwdt | i_wdt_timeout)
      |=> $stable(o_status[4:3])) else $error("status bits 4:3 written");
   chk_ovf_cause: assert property ($rose(o_stack_overflow_flag)
      |-> $past(i_call | i_call_via_w | i_int_vector)) else $error("overflow without push");
   chk_fault_pc: assert property (o_fault_reset
      |-> o_pc == 15'h0 && $past(i_stack_fault_reset_enable)) else $error("fault reset wrong");
   cover property (o_fault_reset);
   cover property (o_stack_overflow_flag);
   cover property (i_branch_relative && i_rel_offset[8]);
endmodule
bind pcstk_unit pcstk_unit_props #(.DEPTH_LOG2(DEPTH_LOG2)) pcstk_unit_props_i (.*);

// ### test/pcstk_decode_model.sv
// decode model: turns a command code into one-cycle instruction pulses
module pcstk_decode_model (
   input wire [2:0] i_cmd,
   output logic o_fetch, o_call, o_call_via_w, o_int_vector, o_return, o_branch_by_w,
   output logic o_branch_relative
);
   timeunit 1ns;
   timeprecision 1ps;
   // code 0 is idle, codes 1..7 select one pulse each
   assign {o_branch_relative, o_branch_by_w, o_return, o_int_vector, o_call_via_w, o_call,
      o_fetch} = 7'((8'h01 << i_cmd) >> 1);
endmodule

// ### test/pcstk_unit_tb_top.sv
// testbench for the program counter, stack and status unit
`include "pcstk_consts.vh"
module pcstk_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_core_clk = 0, i_nrst = 0, fre = 0, i_wr = 0, i_rd = 0, slp = 0, clrw = 0;
   logic alu_v = 0, alu_s = 0, alu_u = 0;
   logic [2:0] cmd = 3'h0;
   logic [10:0] opnd = 11'h0;
   logic [7:0] i_wdata = 8'h0, alu_a = 8'h0, alu_b = 8'h0;
   logic [11:0] i_addr = 12'h0;
   wire f, c, cw, iv, rt, bw, br, ovf, unf, frst;
   wire [14:0] o_pc;
   wire [7:0] o_rdata;
   wire [4:0] o_status;
   int num_errors = 0, n_compared = 0, cyc = 0;
   logic [28:0] rows [11] = '{{3'h1, 11'h0, 15'h0001}, {3'h1, 11'h0, 15'h0002},
      {3'h2, 11'h123, 15'h0123}, {3'h6, 11'h010, 15'h0134}, {3'h7, 11'h1F0, 15'h0125},
      {3'h5, 11'h0, 15'h0003}, {3'h3, 11'h080, 15'h0080}, {3'h5, 11'h0, 15'h0004},
      {3'h7, 11'h0FF, 15'h0104}, {3'h4, 11'h0, 15'h0004}, {3'h5, 11'h0, 15'h0104}};
   pcstk_decode_model pcstk_decode_model_i (.i_cmd(cmd), .o_fetch(f), .o_call(c),
      .o_call_via_w(cw), .o_int_vector(iv), .o_return(rt), .o_branch_by_w(bw),
      .o_branch_relative(br));
   pcstk_unit pcstk_unit_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_ce(1'b1),
      .i_stack_fault_reset_enable(fre), .i_fetch(f), .i_call(c), .i_call_via_w(cw),
      .i_branch_by_w(bw), .i_branch_relative(br), .i_int_vector(iv), .i_return(rt),
      .i_operand(opnd), .i_rel_offset(opnd[8:0]), .i_working_register(opnd[7:0]),
      .i_alu_valid(alu_v), .i_alu_sub(alu_s), .i_alu_a(alu_a), .i_alu_b(alu_b),
      .i_alu_logic(1'b0), .i_alu_logic_result(8'h00), .i_alu_upd_z(alu_u),
      .i_alu_upd_cdc(alu_u), .i_por(1'b0), .i_clrwdt(clrw), .i_sleep(slp),
      .i_wdt_timeout(1'b0), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_pc(o_pc), .o_rdata(o_rdata), .o_status(o_status), .o_stack_overflow_flag(ovf),
      .o_stack_underflow_flag(unf), .o_fault_reset(frst));
   // ---
   // helpers
   // ---
   task automatic close_out;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [14:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic op(input logic [2:0] k, input logic [10:0] v);
      @(posedge i_core_clk) {cmd, opnd} <= {k, v};
      @(posedge i_core_clk) cmd <= 3'h0;
      #1;
   endtask
   // write strobe, optionally alongside an alu flag update
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [2:0] alu);
      @(posedge i_core_clk) {i_addr, i_wdata, i_wr, alu_v, alu_u, alu_s} <= {a, d, 1'b1, alu};
      @(posedge i_core_clk) {i_wr, alu_v, alu_u} <= 3'h0;
      #1;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge i_core_clk) {i_addr, i_rd} <= {a, 1'b1};
      @(posedge i_core_clk) i_rd <= 1'b0;
      #1;
      chk("rdata", {7'h0, o_rdata}, {7'h0, e});
   endtask
   initial begin
      forever #10 i_core_clk = ~i_core_clk;
   end
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         num_errors++;
         close_out();
      end
   end
   // ---
   // main sequence
   // ---
   initial begin
      repeat (8) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      #1;
      chk("pc", o_pc, 15'h0);
      chk("status", {10'h0, o_status}, 15'h0018);
      for (int i = 0; i < 11; i++) begin
         op(rows[i][28:26], rows[i][25:15]);
         chk("pc", o_pc, rows[i][14:0]);
      end
      wr(`PCSTK_ADDR_PC_LATCH, 8'h15, 3'h0);
      wr(`PCSTK_ADDR_PC_LOW, 8'h3C, 3'h0);
      chk("pc", o_pc, 15'h153C);
      op(3'h2, 11'h7FF);
      chk("pc", o_pc, 15'h17FF);
      rd(`PCSTK_ADDR_PC_LATCH, 8'h15);
      rd(`PCSTK_ADDR_STK_POINTER, 8'h00);
      rd(`PCSTK_ADDR_TOS_LOW, 8'h3D);
      rd(`PCSTK_ADDR_TOS_HIGH, 8'h15);
      wr(`PCSTK_ADDR_TOS_LOW, 8'h40, 3'h0);
      op(3'h5, 11'h0);
      chk("pc", o_pc, 15'h1540);
      wr(`PCSTK_ADDR_STATUS, 8'h00, 3'h0);
      rd(`PCSTK_ADDR_STATUS, 8'h18);
      rd(12'h123, 8'h00);
      alu_a <= 8'h0F;
      alu_b <= 8'h01;
      wr(`PCSTK_ADDR_STATUS, 8'h07, 3'h6);
      chk("status", {10'h0, o_status}, 15'h001A);
      alu_a <= 8'h10;
      wr(`PCSTK_ADDR_STATUS, 8'h07, 3'h7);
      chk("status", {10'h0, o_status}, 15'h0019);
      @(posedge i_core_clk) slp <= 1'b1;
      @(posedge i_core_clk) {slp, clrw} <= 2'b01;
      #1 chk("power_down", {14'h0, o_status[3]}, 15'h0);
      @(posedge i_core_clk) clrw <= 1'b0;
      #1 chk("power_down", {14'h0, o_status[3]}, 15'h1);
      op(3'h5, 11'h0);
      chk("unf", {14'h0, unf}, 15'h1);
      wr(`PCSTK_ADDR_PC_LOW, 8'h55, 3'h0);
      // the wrapped underflow left the pointer at 30: make the stack empty again
      wr(`PCSTK_ADDR_STK_POINTER, 8'h1F, 3'h0);
      @(posedge i_core_clk) fre <= 1'b1;
      op(3'h5, 11'h0);
      chk("pc", o_pc, 15'h0);
      chk("frst", {14'h0, frst}, 15'h1);
      @(posedge i_core_clk) fre <= 1'b0;
      repeat (17) op(3'h2, 11'h0);
      chk("ovf", {14'h0, ovf}, 15'h1);
      chk("pc", o_pc, 15'h1000);
      rd(`PCSTK_ADDR_TOS_LOW, 8'h01);
      rd(`PCSTK_ADDR_TOS_HIGH, 8'h10);
      close_out();
   end
endmodule
